// ==== hw/uoif_flag_bank.sv ====
// Interrupt flag register bank of the USB module.
//
// Functional notes
// RULE_01: Software clears a flag by writing one; writing zero keeps it.
// RULE_02: Token completion sets bit 3 and exposes that token's status.
// RULE_03: Clearing token completion advances the token status queue.
// RULE_04: Bit 2 sets on received frame start or host frame threshold.
// RULE_05: Bit 1 sets only for errors enabled in the error enable register.
// RULE_06: In device role bit 0 flags a valid bus reset.
// RULE_07: In host role bit 0 flags peripheral detachment.
// RULE_08: Attach counts only with host role, 2.5 us idle, and no SE0.
// RULE_09: Software keeps resume interrupt off outside suspend.
// RULE_10: A set and a clear in one cycle leave the flag set.
// RULE_11: Unimplemented upper bits read zero and ignore writes.
`timescale 1ns/10ps
`include "uoif_params.svh"
module uoif_flag_bank
	import uoif_pkg::*;
#(
	parameter int TOK_DEPTH = 4
)(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire uoif_pkg::uoif_addr_t reg_addr,
	input  wire uoif_pkg::uoif_word_t reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output uoif_pkg::uoif_word_t reg_rdata,
	input  wire logic       ev_token_done,
	input  wire uoif_pkg::uoif_tok_t ev_token_info,
	input  wire logic       ev_frame_rx,
	input  wire logic       ev_frame_threshold,
	input  wire uoif_pkg::uoif_byte_t ev_errors,
	input  wire logic       ev_bus_reset,
	input  wire logic       ev_detach,
	input  wire logic       ev_attach,
	input  wire logic       ev_resume,
	input  wire logic       ev_idle,
	input  wire logic       ev_stall,
	input  wire logic       bus_active_pin,
	input  wire logic       line_se0_pin,
	output logic            irq,
	output logic            host_role_enable,
	output uoif_pkg::uoif_byte_t otg_line_ctrl,
	output uoif_pkg::uoif_byte_t pwr_ctrl
);
	import uoif_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State.
	typedef struct packed {
		uoif_byte_t otg;
		uoif_byte_t pwr;
		uoif_byte_t flags;
		uoif_byte_t mask;
		uoif_byte_t err_en;
		logic       host;
		uoif_word_t rdata;
		logic       irq;
		logic [1:0] act_sync;
		logic [1:0] se0_sync;
	} uoif_bank_s;
	uoif_bank_s b_ff;
	uoif_bank_s nxt_b;

	uoif_tok_if tq ();
	logic       idle_met;
	uoif_byte_t set_vec;
	uoif_byte_t clr_vec;
	logic       wr_flags;

	uoif_tok_queue #(.DEPTH(TOK_DEPTH)) u_queue (
		.clk   (clk),
		.rst_b (rst_b),
		.q     (tq.queue)
	);

	uoif_idle_timer u_idle (
		.clk        (clk),
		.rst_b      (rst_b),
		.bus_active (b_ff.act_sync[1]),
		.idle_met   (idle_met)
	);

	////////////////////////////////////////////////////////////////////////
	// Event vector.
	always_comb
	begin
		set_vec = '0;
		// RULE_02: token completion flag
		set_vec[`UOIF_BIT_TOKEN] = ev_token_done;
		// RULE_04: frame start sources
		set_vec[`UOIF_BIT_FRAME] = b_ff.host ? ev_frame_threshold : ev_frame_rx;
		// RULE_05: masked error summary
		set_vec[`UOIF_BIT_ERROR] = |(ev_errors & b_ff.err_en);
		// RULE_06: device bus reset
		// RULE_07: host detach
		set_vec[`UOIF_BIT_BUS_RESET] = b_ff.host ? ev_detach : ev_bus_reset;
		// RULE_08: attach qualification
		set_vec[`UOIF_BIT_ATTACH] = ev_attach && b_ff.host && idle_met &&
			!b_ff.se0_sync[1];
		set_vec[`UOIF_BIT_RESUME] = ev_resume;
		set_vec[`UOIF_BIT_IDLE]   = ev_idle;
		set_vec[`UOIF_BIT_STALL]  = ev_stall;
	end

	assign wr_flags = reg_wr && (reg_addr == `UOIF_OFF_FLAGS);
	// RULE_01: write one to clear
	assign clr_vec  = wr_flags ? reg_wdata[7:0] : 8'h00;

	assign tq.push      = ev_token_done;
	assign tq.push_data = ev_token_info;
	// RULE_03: clear advances queue
	assign tq.pop = wr_flags && reg_wdata[`UOIF_BIT_TOKEN] &&
		b_ff.flags[`UOIF_BIT_TOKEN];

	////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb
	begin
		nxt_b = b_ff;
		nxt_b.act_sync = {b_ff.act_sync[0], bus_active_pin};
		nxt_b.se0_sync = {b_ff.se0_sync[0], line_se0_pin};
		// RULE_10: set wins over clear
		nxt_b.flags = (b_ff.flags & ~clr_vec) | set_vec;
		// RULE_11: upper bits dropped
		if (reg_wr)
		begin
			case (reg_addr)
				`UOIF_OFF_OTG_CTRL:   nxt_b.otg = reg_wdata[7:0];
				`UOIF_OFF_PWR_CTRL:
					nxt_b.pwr = reg_wdata[7:0] & `UOIF_PWR_MASK;
				`UOIF_OFF_FLAG_MASK:  nxt_b.mask = reg_wdata[7:0];
				`UOIF_OFF_ERR_ENABLE: nxt_b.err_en = reg_wdata[7:0];
				`UOIF_OFF_ROLE_CTRL:  nxt_b.host = reg_wdata[0];
				default:              nxt_b.host = b_ff.host;
			endcase
		end
		nxt_b.rdata = '0;
		// RULE_11: upper bits read zero
		if (reg_rd)
		begin
			case (reg_addr)
				`UOIF_OFF_OTG_CTRL:   nxt_b.rdata[7:0] = b_ff.otg;
				`UOIF_OFF_PWR_CTRL:   nxt_b.rdata[7:0] = b_ff.pwr;
				`UOIF_OFF_FLAGS:      nxt_b.rdata[7:0] = b_ff.flags;
				`UOIF_OFF_FLAG_MASK:  nxt_b.rdata[7:0] = b_ff.mask;
				`UOIF_OFF_ERR_ENABLE: nxt_b.rdata[7:0] = b_ff.err_en;
				// RULE_02: token status view
				`UOIF_OFF_TOK_STATUS:
					nxt_b.rdata[5:0] = {tq.full, tq.empty, tq.head};
				`UOIF_OFF_ROLE_CTRL:  nxt_b.rdata[0] = b_ff.host;
				default:              nxt_b.rdata = '0;
			endcase
		end
		nxt_b.irq = |(nxt_b.flags & nxt_b.mask);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			b_ff <= '0;
		else
			b_ff <= nxt_b;
	end

	assign reg_rdata        = b_ff.rdata;
	assign irq              = b_ff.irq;
	assign host_role_enable = b_ff.host;
	assign otg_line_ctrl    = b_ff.otg;
	assign pwr_ctrl         = b_ff.pwr;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	token_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
		ev_token_done |=> b_ff.flags[`UOIF_BIT_TOKEN])
		else $error("Token flag not set.");

	set_priority_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		(ev_stall && wr_flags && reg_wdata[7]) |=> b_ff.flags[7])
		else $error("Set lost to clear.");

	clear_one_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		(wr_flags && reg_wdata[6] && !set_vec[6]) |=> !b_ff.flags[6])
		else $error("Flag not cleared.");

	clear_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		(b_ff.flags[4] && wr_flags && !reg_wdata[4]) |=> b_ff.flags[4])
		else $error("Zero write cleared flag.");

	queue_pop_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		(wr_flags && reg_wdata[3] && b_ff.flags[3]) |-> tq.pop)
		else $error("Queue not advanced.");

	error_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
		(!b_ff.flags[1] && !(|(ev_errors & b_ff.err_en))) |=> !b_ff.flags[1])
		else $error("Masked error set flag.");

	attach_qual_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
		(!b_ff.flags[6] && !b_ff.host) |=> !b_ff.flags[6])
		else $error("Attach outside host role.");

	reset_dev_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
		(!b_ff.host && ev_bus_reset) |=> b_ff.flags[0])
		else $error("Bus reset not flagged.");

	detach_host_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
		(b_ff.host && ev_detach) |=> b_ff.flags[0])
		else $error("Detach not flagged.");

	frame_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		(!b_ff.host && ev_frame_rx) |=> b_ff.flags[2])
		else $error("Frame start not flagged.");

	upper_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		reg_rd |=> (reg_rdata[31:8] == 24'h000000))
		else $error("Upper bits not zero.");

	////////////////////////////////////////////////////////////////////////
	// Checks of register access.
	irq_level_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		irq == |(b_ff.flags & b_ff.mask))
		else $error("Interrupt level wrong.");

	rd_idle_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		!reg_rd |=> (reg_rdata == 32'h00000000))
		else $error("Read data not zero when idle.");

	rd_flags_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		(reg_rd && reg_addr == `UOIF_OFF_FLAGS) |=>
		(reg_rdata[7:0] == $past(b_ff.flags)))
		else $error("Flag read wrong.");

	rd_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_rd && reg_addr == `UOIF_OFF_FLAG_MASK) |=>
		(reg_rdata[7:0] == $past(b_ff.mask)))
		else $error("Mask read wrong.");

	mask_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_wr && reg_addr == `UOIF_OFF_FLAG_MASK) |=>
		(b_ff.mask == $past(reg_wdata[7:0])))
		else $error("Mask write lost.");

	err_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
		(reg_wr && reg_addr == `UOIF_OFF_ERR_ENABLE) |=>
		(b_ff.err_en == $past(reg_wdata[7:0])))
		else $error("Error enable write lost.");

	role_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
		(reg_wr && reg_addr == `UOIF_OFF_ROLE_CTRL) |=>
		(host_role_enable == $past(reg_wdata[0])))
		else $error("Role write lost.");

	otg_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_wr && reg_addr == `UOIF_OFF_OTG_CTRL) |=>
		(otg_line_ctrl == $past(reg_wdata[7:0])))
		else $error("Line control write lost.");

	pwr_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_wr && reg_addr == `UOIF_OFF_PWR_CTRL) |=>
		(pwr_ctrl == ($past(reg_wdata[7:0]) & `UOIF_PWR_MASK)))
		else $error("Power control write wrong.");

	pwr_bits_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(pwr_ctrl & ~`UOIF_PWR_MASK) == 8'h00)
		else $error("Fixed power bit set.");

	rd_tok_hi_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_rd && reg_addr == `UOIF_OFF_TOK_STATUS) |=>
		(reg_rdata[31:6] == 26'h0000000))
		else $error("Token status upper bits set.");

	rd_role_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_rd && reg_addr == `UOIF_OFF_ROLE_CTRL) |=>
		(reg_rdata[31:1] == 31'h00000000))
		else $error("Role upper bits set.");

	rd_unmap_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		(reg_rd && reg_addr > `UOIF_OFF_ROLE_CTRL) |=>
		(reg_rdata == 32'h00000000))
		else $error("Unmapped read not zero.");

	////////////////////////////////////////////////////////////////////////
	// Checks of flag events.
	err_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
		|(ev_errors & b_ff.err_en) |=> b_ff.flags[1])
		else $error("Enabled error not flagged.");

	frm_host_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		(b_ff.host && ev_frame_threshold) |=> b_ff.flags[2])
		else $error("Frame threshold not flagged.");

	frm_dev_q_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		(!b_ff.host && !ev_frame_rx && !b_ff.flags[2]) |=> !b_ff.flags[2])
		else $error("Stray device frame flag.");

	frm_host_q_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		(b_ff.host && !ev_frame_threshold && !b_ff.flags[2]) |=>
		!b_ff.flags[2])
		else $error("Stray host frame flag.");

	rst_quiet_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
		(!b_ff.host && !ev_bus_reset && !b_ff.flags[0]) |=> !b_ff.flags[0])
		else $error("Stray bus reset flag.");

	det_quiet_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
		(b_ff.host && !ev_detach && !b_ff.flags[0]) |=> !b_ff.flags[0])
		else $error("Stray detach flag.");

	att_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
		(ev_attach && b_ff.host && idle_met && !b_ff.se0_sync[1]) |=>
		b_ff.flags[6])
		else $error("Valid attach not flagged.");

	att_se0_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
		(!b_ff.flags[6] && b_ff.se0_sync[1]) |=> !b_ff.flags[6])
		else $error("Attach flagged during SE0.");

	att_idle_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
		(!b_ff.flags[6] && !idle_met) |=> !b_ff.flags[6])
		else $error("Attach flagged without idle.");

	resume_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		ev_resume |=> b_ff.flags[5])
		else $error("Resume not flagged.");

	idle_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		ev_idle |=> b_ff.flags[4])
		else $error("Idle not flagged.");

	stall_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		ev_stall |=> b_ff.flags[7])
		else $error("Stall not flagged.");

	keep_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		(b_ff.flags[7] && !(wr_flags && reg_wdata[7])) |=> b_ff.flags[7])
		else $error("Flag lost without clear.");

	pop_guard_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		tq.pop |-> b_ff.flags[3])
		else $error("Queue advanced without flag.");

	clr_tok_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		(wr_flags && reg_wdata[3] && !ev_token_done) |=> !b_ff.flags[3])
		else $error("Token flag not cleared.");

	push_tok_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
		(ev_token_done && !tq.full) |=> !tq.empty)
		else $error("Token status not queued.");

	tok_view_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
		(reg_rd && reg_addr == `UOIF_OFF_TOK_STATUS) |=>
		(reg_rdata[3:0] == $past(tq.head)))
		else $error("Token status read wrong.");

	tok_empty_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		(reg_rd && reg_addr == `UOIF_OFF_TOK_STATUS) |=>
		(reg_rdata[4] == $past(tq.empty)))
		else $error("Queue empty read wrong.");
endmodule : uoif_flag_bank

// ==== hw/uoif_idle_timer.sv ====
// Bus idle timer qualifying the attach event.
`timescale 1ns/10ps
`include "uoif_params.svh"
module uoif_idle_timer
	import uoif_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic bus_active,
	output logic      idle_met
);
	import uoif_pkg::*;
	localparam int CYC = `UOIF_IDLE_CYCLES;
	typedef struct packed {
		uoif_idle_e st;
		logic [7:0] cnt;
	} uoif_t_s;
	uoif_t_s t_ff;
	uoif_t_s nxt_t;

	always_comb
	begin
		nxt_t = t_ff;
		case (t_ff.st)
			UOIF_IDLE_WAIT:
			begin
				nxt_t.cnt = '0;
				if (!bus_active)
					nxt_t.st = UOIF_IDLE_COUNT;
			end
			UOIF_IDLE_COUNT:
			begin
				nxt_t.cnt = t_ff.cnt + 8'h01;
				if (bus_active)
					nxt_t.st = UOIF_IDLE_WAIT;
				else if (t_ff.cnt == 8'(CYC - 2))
					nxt_t.st = UOIF_IDLE_MET;
			end
			UOIF_IDLE_MET:
				if (bus_active)
					nxt_t.st = UOIF_IDLE_WAIT;
			default:
				nxt_t.st = UOIF_IDLE_WAIT;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			t_ff <= '{st: UOIF_IDLE_WAIT, cnt: 8'h00};
		else
			t_ff <= nxt_t;
	end

	assign idle_met = (t_ff.st == UOIF_IDLE_MET);
endmodule : uoif_idle_timer

// ==== hw/uoif_params.svh ====
// Offsets, field positions, reset values and timing counts of the flag bank.
`ifndef UOIF_PARAMS_SVH
`define UOIF_PARAMS_SVH

`define UOIF_ADDR_W          8
`define UOIF_OFF_OTG_CTRL    8'h00
`define UOIF_OFF_PWR_CTRL    8'h04
`define UOIF_OFF_FLAGS       8'h08
`define UOIF_OFF_FLAG_MASK   8'h0C
`define UOIF_OFF_ERR_ENABLE  8'h10
`define UOIF_OFF_TOK_STATUS  8'h14
`define UOIF_OFF_ROLE_CTRL   8'h18

`define UOIF_BIT_BUS_RESET   0
`define UOIF_BIT_ERROR       1
`define UOIF_BIT_FRAME       2
`define UOIF_BIT_TOKEN       3
`define UOIF_BIT_IDLE        4
`define UOIF_BIT_RESUME      5
`define UOIF_BIT_ATTACH      6
`define UOIF_BIT_STALL       7

`define UOIF_PWR_MASK        8'h1B
`define UOIF_RESET_BYTE      8'h00

`define UOIF_CLK_MHZ         50
`define UOIF_IDLE_NS         2500
`define UOIF_IDLE_CYCLES     ((`UOIF_IDLE_NS * `UOIF_CLK_MHZ + 999) / 1000)

`endif

// ==== hw/uoif_pkg.sv ====
// Types shared by the flag bank modules.
package uoif_pkg;
	typedef logic [7:0]  uoif_byte_t;
	typedef logic [31:0] uoif_word_t;
	typedef logic [7:0]  uoif_addr_t;
	typedef logic [3:0]  uoif_tok_t;
	typedef enum logic [1:0] {
		UOIF_IDLE_WAIT,
		UOIF_IDLE_COUNT,
		UOIF_IDLE_MET
	} uoif_idle_e;
endpackage : uoif_pkg

// ==== hw/uoif_tok_if.sv ====
// Link between the flag bank and its token status queue.
`timescale 1ns/10ps
interface uoif_tok_if;
	import uoif_pkg::*;
	logic      push;
	uoif_tok_t push_data;
	logic      pop;
	uoif_tok_t head;
	logic      empty;
	logic      full;
	modport bank  (output push, output push_data, output pop,
		input head, input empty, input full);
	modport queue (input push, input push_data, input pop,
		output head, output empty, output full);
endinterface : uoif_tok_if

// ==== hw/uoif_tok_queue.sv ====
// Token status queue, advanced when software clears token completion.
`timescale 1ns/10ps
module uoif_tok_queue
	import uoif_pkg::*;
#(
	parameter int DEPTH = 4
)(
	input  wire logic clk,
	input  wire logic rst_b,
	uoif_tok_if.queue q
);
	import uoif_pkg::*;
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		uoif_tok_t [DEPTH-1:0] mem;
		logic [AW-1:0]         rd;
		logic [AW-1:0]         wr;
		logic [AW:0]           cnt;
	} uoif_q_s;
	uoif_q_s q_ff;
	uoif_q_s nxt_q;
	logic    do_push;
	logic    do_pop;

	assign do_push = q.push && (q_ff.cnt != (AW+1)'(DEPTH));
	assign do_pop  = q.pop && (q_ff.cnt != '0);

	always_comb
	begin
		nxt_q = q_ff;
		if (do_push)
		begin
			nxt_q.mem[q_ff.wr] = q.push_data;
			nxt_q.wr = (q_ff.wr == AW'(DEPTH-1)) ? '0 : q_ff.wr + 1'b1;
		end
		if (do_pop)
			nxt_q.rd = (q_ff.rd == AW'(DEPTH-1)) ? '0 : q_ff.rd + 1'b1;
		nxt_q.cnt = q_ff.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			q_ff <= '0;
		else
			q_ff <= nxt_q;
	end

	assign q.head  = q_ff.mem[q_ff.rd];
	assign q.empty = (q_ff.cnt == '0);
	assign q.full  = (q_ff.cnt == (AW+1)'(DEPTH));
endmodule : uoif_tok_queue

// ==== tb/uoif_flag_bank_tb_top.sv ====
// Self-checking bench of the interrupt flag bank.
`timescale 1ns/10ps
module uoif_flag_bank_tb_top;
	import uoif_pkg::*;
	logic       clk, rst_b, wr_s, rd_s, fire, bact, se0, irq, host;
	logic [3:0] sel;
	uoif_addr_t addr;
	uoif_word_t wd, rdat;
	uoif_byte_t errs, e_err, otg, pwr;
	uoif_tok_t  info;
	logic       e_tok, e_frx, e_fth, e_brst, e_det, e_att, e_res, e_idl, e_stl;
	int         n_errors, compares;
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	uoif_flag_bank DUT (.clk(clk), .rst_b(rst_b), .reg_addr(addr),
		.reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat),
		.ev_token_done(e_tok), .ev_token_info(info), .ev_frame_rx(e_frx),
		.ev_frame_threshold(e_fth), .ev_errors(e_err), .ev_bus_reset(e_brst),
		.ev_detach(e_det), .ev_attach(e_att), .ev_resume(e_res),
		.ev_idle(e_idl), .ev_stall(e_stl), .bus_active_pin(bact),
		.line_se0_pin(se0), .irq(irq), .host_role_enable(host),
		.otg_line_ctrl(otg), .pwr_ctrl(pwr));
	uoif_sie_model SIE (.fire(fire), .sel(sel), .errs(errs), .e_tok(e_tok),
		.e_frx(e_frx), .e_fth(e_fth), .e_brst(e_brst), .e_det(e_det),
		.e_att(e_att), .e_res(e_res), .e_idl(e_idl), .e_stl(e_stl),
		.e_err(e_err));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input uoif_word_t e, uoif_word_t g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(input uoif_addr_t a, input uoif_word_t d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wd   <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input uoif_addr_t a, input uoif_word_t e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("reg_rdata", e, rdat);
	endtask : rd
	task automatic ev(input logic [3:0] s);
		@(posedge clk);
		fire <= 1'b1;
		sel  <= s;
		@(posedge clk);
		fire <= 1'b0;
	endtask : ev
	task automatic final_report();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h08, 32'h0);
		rd(8'h1C, 32'h0);
		wr(8'h0C, 32'hFFFFFFFF);
		rd(8'h0C, 32'h000000FF);
		wr(8'h0C, 32'h0);
		wr(8'h00, 32'h000000A5);
		rd(8'h00, 32'h000000A5);
		chk("otg_line_ctrl", 32'h000000A5, {24'h0, otg});
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h04, 32'h0000001B);
		chk("pwr_ctrl", 32'h0000001B, {24'h0, pwr});
	endtask : t_reset
	task automatic t_simple();
		logic [3:0] s [5] = '{4'h1, 4'h3, 4'h7, 4'h8, 4'h6};
		int         b [5] = '{2, 1'b0, 4, 7, 5};
		// Resume is raised but its mask stays off throughout.
		for (int i = 0; i < 5; i++)
		begin
			ev(s[i]);
			rd(8'h08, 32'h1 << b[i]);
			wr(8'h08, ~(32'h1 << b[i]));
			rd(8'h08, 32'h1 << b[i]);
			wr(8'h08, 32'h1 << b[i]);
			rd(8'h08, 32'h0);
		end
	endtask : t_simple
	task automatic t_error();
		wr(8'h10, 32'h1);
		errs <= 8'h02;
		ev(4'h9);
		rd(8'h08, 32'h0);
		errs <= 8'h01;
		ev(4'h9);
		rd(8'h08, 32'h2);
		wr(8'h08, 32'h2);
	endtask : t_error
	task automatic t_collide_irq();
		ev(4'h1);
		@(posedge clk);
		fire <= 1'b1;
		sel  <= 4'h1;
		wr_s <= 1'b1;
		addr <= 8'h08;
		wd   <= 32'h4;
		@(posedge clk);
		fire <= 1'b0;
		wr_s <= 1'b0;
		rd(8'h08, 32'h4);
		wr(8'h0C, 32'h4);
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h0C, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'h08, 32'h4);
	endtask : t_collide_irq
	task automatic t_host();
		wr(8'h18, 32'h1);
		ev(4'h2);
		chk("host_role_enable", 32'h1, {31'h0, host});
		rd(8'h08, 32'h4);
		wr(8'h08, 32'h4);
		ev(4'h4);
		rd(8'h08, 32'h1);
		wr(8'h08, 32'h1);
		bact <= 1'b1;
		repeat (4) @(posedge clk);
		ev(4'h5);
		rd(8'h08, 32'h0);
		bact <= 1'b0;
		se0  <= 1'b1;
		repeat (140) @(posedge clk);
		ev(4'h5);
		rd(8'h08, 32'h0);
		se0 <= 1'b0;
		repeat (4) @(posedge clk);
		ev(4'h5);
		rd(8'h08, 32'h40);
		wr(8'h08, 32'h40);
		wr(8'h18, 32'h0);
	endtask : t_host
	task automatic t_token();
		info <= 4'hA;
		ev(4'h0);
		info <= 4'h5;
		ev(4'h0);
		rd(8'h08, 32'h8);
		rd(8'h14, 32'h0A);
		wr(8'h08, 32'h8);
		rd(8'h14, 32'h05);
	endtask : t_token
	////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_b, wr_s, rd_s, fire, bact, se0} = '0;
		{sel, addr, wd, errs, info, n_errors, compares} = '0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_simple();
		t_error();
		t_collide_irq();
		t_host();
		t_token();
		final_report();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule : uoif_flag_bank_tb_top

// ==== tb/uoif_sie_model.sv ====
// Serial engine stand-in that pulses one selected flag event.
`timescale 1ns/10ps
module uoif_sie_model
(
	input  wire logic             fire,
	input  wire logic [3:0]       sel,
	input  wire uoif_pkg::uoif_byte_t errs,
	output logic                  e_tok,
	output logic                  e_frx,
	output logic                  e_fth,
	output logic                  e_brst,
	output logic                  e_det,
	output logic                  e_att,
	output logic                  e_res,
	output logic                  e_idl,
	output logic                  e_stl,
	output uoif_pkg::uoif_byte_t  e_err
);
	import uoif_pkg::*;
	assign e_tok  = fire && (sel == 4'h0);
	assign e_frx  = fire && (sel == 4'h1);
	assign e_fth  = fire && (sel == 4'h2);
	assign e_brst = fire && (sel == 4'h3);
	assign e_det  = fire && (sel == 4'h4);
	assign e_att  = fire && (sel == 4'h5);
	assign e_res  = fire && (sel == 4'h6);
	assign e_idl  = fire && (sel == 4'h7);
	assign e_stl  = fire && (sel == 4'h8);
	assign e_err  = (fire && (sel == 4'h9)) ? errs : 8'h00;
endmodule : uoif_sie_model
